/* logic/amp_supervisor_consts.vh */
`ifndef AMP_SUPERVISOR_CONSTS_VH
`define AMP_SUPERVISOR_CONSTS_VH

// Register indices, byte address is index times four
`define IDX_MISC1 8'h01
`define IDX_STATE 8'h02
`define IDX_MISC3 8'h21
`define IDX_CLIPWIN 8'h23
`define IDX_FSTAT 8'h30
`define IDX_WSTAT 8'h31
`define IDX_FMASK 8'h32
`define IDX_WMASK 8'h33
`define IDX_MODE 8'h34

// Field positions
`define MISC3_CLEAR 7
`define MISC3_AUTOREC 3
`define MISC3_CLIPFREE 0
`define MISC1_CLAMP 4
`define MISC1_THR_LO 5
`define MISC1_THR_HI 6

// Reset values
`define MISC1_RST 8'h00
`define MISC3_RST 8'h00
`define CLIPWIN_RST 8'h14
`define REQ_RST 2'h1
`define FMASK_RST 4'h0
`define WMASK_RST 3'h0

// Event pin positions
`define EV_UV_BAT 0
`define EV_UV_STG 1
`define EV_OV_STG 2
`define EV_HEAT_SD 3
`define EV_CLK_ERR 4
`define EV_CH_OC 5
`define EV_CH_DC 6
`define EV_HEAT_WG 7
`define EV_HEAT_WC 8
`define EV_CLAMP 9

// Fault mask categories
`define FM_VOLT 0
`define FM_HEAT 1
`define FM_CLK 2
`define FM_CHAN 3

// Warning status and mask positions
`define WS_POR 0
`define WS_CLIP 1
`define WS_HEAT 2
`define WS_CLAMP 3
`define WM_CLIP 0
`define WM_HEAT 1
`define WM_CLAMP 2

// Timing
`define CLK_KHZ 40000
`define RAMP_MS 5
`define RAMP_CYC (`RAMP_MS * `CLK_KHZ)

`endif

/* logic/amp_supervisor.v */
// What this block does
// - Low battery or stage supply asserts fault pin and sets its status bit.
// - Power-on reset quiets the control port and restores every register default.
// - Power-up or power-on reset sets the reset warning bit and warning pin.
// - Stage supply too high asserts fault pin and sets its status bit.
// - Fault pin active low for channel, heat shutdown, supply and clock faults.
// - Fault pin stays asserted until host writes clear bit 7 at 0x21.
// - Heat shutdown fault pin releases itself once temperature recovers automatically.
// - Fault status bits stay set until the clear bit is written.
// - Fault masks gate only the pin; all unmasked after reset.
// - Warning pin active low for clipping, heat warning, current clamp, reset.
// - Clipping flagged after programmable consecutive full-modulation PWM clocks, default 20.
// - Latching clip status bit stays set until the clear bit is written.
// - Heat warning from global or channel warning; threshold in 0x01 bits 6:5.
// - Warning masks gate only the pin; all reported by default.
// - Warning pin latched until the clear bit is written.
// - Active-low mute pin mutes output; pulled low when undriven.
// - Standby pin shuts down, ramping outputs within 5 ms unless in high-Z.
// - Four states standby, high-Z, mute, play; registers usable in all.
// - Reset gives standby; supply, clock and channel faults and heat shutdown give high-Z.
// - Non-latching clip mode follows full duty directly.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "amp_supervisor_consts.vh"

module amp_supervisor #(
    parameter RAMP_CYC = `RAMP_CYC,
    parameter RAMP_W = 18
) (
    // Clock, reset, enable
    input wire core_clk,
    input wire arst_n,
    input wire clk_en,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Detector pins, asynchronous
    input wire [9:0] ev_pin,
    // PWM modulator, same clock
    input wire pwm_tick,
    input wire max_mod,
    // Control pins, active low
    input wire mute_n,
    input wire standby_n,
    // Open-drain status pins
    output wire fault_n_o,
    output wire fault_n_oe,
    output wire warn_n_o,
    output wire warn_n_oe,
    // Output stage control
    output wire [2:0] stage_state,
    output wire osc_run,
    output wire [1:0] heat_thr,
    output wire clamp_lvl
);

    localparam [2:0] ST_STBY = 3'h0;
    localparam [2:0] ST_HIZ = 3'h1;
    localparam [2:0] ST_MUTE = 3'h2;
    localparam [2:0] ST_PLAY = 3'h3;
    localparam [2:0] ST_RAMP = 3'h4;
    localparam [31:0] RAMP_M1 = RAMP_CYC - 1;
    localparam [RAMP_W-1:0] RAMP_LD = RAMP_M1[RAMP_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    reg [9:0] ev_s1_ff;
    reg [9:0] ev_s2_ff;
    reg [1:0] pin_s1_ff;
    reg [1:0] pin_s2_ff;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ev_s1_ff <= 10'h000;
            ev_s2_ff <= 10'h000;
            pin_s1_ff <= 2'h0;
            pin_s2_ff <= 2'h0;
        end else if (clk_en) begin
            ev_s1_ff <= ev_pin;
            ev_s2_ff <= ev_s1_ff;
            pin_s1_ff <= {standby_n, mute_n};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // Undriven mute pin reads low, so default is muted
    wire mute_req = ~pin_s2_ff[0];
    wire stby_req = ~pin_s2_ff[1];

    wire ev_volt = ev_s2_ff[`EV_UV_BAT] | ev_s2_ff[`EV_UV_STG]
                 | ev_s2_ff[`EV_OV_STG];
    wire ev_hsd = ev_s2_ff[`EV_HEAT_SD];
    wire ev_clk = ev_s2_ff[`EV_CLK_ERR];
    wire ev_chan = ev_s2_ff[`EV_CH_OC] | ev_s2_ff[`EV_CH_DC];
    wire ev_hwarn = ev_s2_ff[`EV_HEAT_WG] | ev_s2_ff[`EV_HEAT_WC];
    wire ev_clamp = ev_s2_ff[`EV_CLAMP];

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state on every access

    reg pready_ff;
    reg pslverr_ff;
    reg [31:0] prdata_ff;
    reg [7:0] misc1_ff;
    reg [7:0] misc3_ff;
    reg [7:0] clipwin_ff;
    reg [1:0] req_ff;
    reg [3:0] fmask_ff;
    reg [2:0] wmask_ff;
    reg [6:0] fstat_ff;
    reg [3:0] wstat_ff;
    reg [2:0] st_ff;
    reg osc_run_ff;

    wire [7:0] idx = paddr[9:2];
    wire in_range = (paddr[11:10] == 2'h0);
    wire acc = psel & penable;
    wire done = acc & pready_ff;
    wire wr_go = done & pwrite & in_range;

    reg hit;
    reg [31:0] rd_val;

    always @* begin
        hit = in_range;
        rd_val = 32'h0000_0000;
        case (idx)
            `IDX_MISC1: rd_val[7:0] = misc1_ff;
            `IDX_STATE: rd_val[1:0] = req_ff;
            `IDX_MISC3: rd_val[7:0] = misc3_ff;
            `IDX_CLIPWIN: rd_val[7:0] = clipwin_ff;
            `IDX_FSTAT: rd_val[6:0] = fstat_ff;
            `IDX_WSTAT: rd_val[3:0] = wstat_ff;
            `IDX_FMASK: rd_val[3:0] = fmask_ff;
            `IDX_WMASK: rd_val[2:0] = wmask_ff;
            `IDX_MODE: rd_val[3:0] = {osc_run_ff, st_ff};
            default: hit = 1'b0;
        endcase
        if (!in_range) begin
            rd_val = 32'h0000_0000;
        end
    end

    // Clear command is a strobe; the bit never stores
    wire clear = wr_go & (idx == `IDX_MISC3) & pwdata[`MISC3_CLEAR];

    // Held quiet through reset, no answer until released
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (clk_en) begin
            if (done) begin
                pready_ff <= 1'b0;
                pslverr_ff <= 1'b0;
            end else if (acc) begin
                pready_ff <= 1'b1;
                pslverr_ff <= ~hit;
                prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
            end
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            misc1_ff <= `MISC1_RST;
            misc3_ff <= `MISC3_RST;
            clipwin_ff <= `CLIPWIN_RST;
            req_ff <= `REQ_RST;
            fmask_ff <= `FMASK_RST;
            wmask_ff <= `WMASK_RST;
        end else if (clk_en && wr_go) begin
            case (idx)
                `IDX_MISC1: misc1_ff <= pwdata[7:0];
                `IDX_STATE: req_ff <= pwdata[1:0];
                `IDX_MISC3: misc3_ff <= {1'b0, pwdata[6:0]};
                `IDX_CLIPWIN: clipwin_ff <= pwdata[7:0];
                `IDX_FMASK: fmask_ff <= pwdata[3:0];
                `IDX_WMASK: wmask_ff <= pwdata[2:0];
                default: misc1_ff <= misc1_ff;
            endcase
        end
    end

    wire autorec = misc3_ff[`MISC3_AUTOREC];
    wire clip_free = misc3_ff[`MISC3_CLIPFREE];

    ////////////////////////////////////////////////////////////////////////////
    // Clip detector

    reg [7:0] clip_cnt_ff;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clip_cnt_ff <= 8'h00;
        end else if (clk_en) begin
            if (!max_mod) begin
                clip_cnt_ff <= 8'h00;
            end else if (pwm_tick && clip_cnt_ff != 8'hFF) begin
                clip_cnt_ff <= clip_cnt_ff + 8'h01;
            end
        end
    end

    wire clip_win = max_mod & (clip_cnt_ff >= clipwin_ff);
    // Free mode follows full duty with no window
    wire clip_evt = clip_free ? max_mod : clip_win;

    ////////////////////////////////////////////////////////////////////////////
    // Status registers; a new event beats a same-cycle clear

    wire [6:0] nxt_fstat = (fstat_ff & {7{~clear}}) | ev_s2_ff[6:0];

    reg [3:0] nxt_wstat;

    always @* begin
        nxt_wstat = wstat_ff & {4{~clear}};
        nxt_wstat[`WS_HEAT] = nxt_wstat[`WS_HEAT] | ev_hwarn;
        nxt_wstat[`WS_CLAMP] = nxt_wstat[`WS_CLAMP] | ev_clamp;
        if (clip_free) begin
            nxt_wstat[`WS_CLIP] = max_mod;
        end else begin
            nxt_wstat[`WS_CLIP] = nxt_wstat[`WS_CLIP] | clip_win;
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fstat_ff <= 7'h00;
            wstat_ff <= 4'h1;
        end else if (clk_en) begin
            fstat_ff <= nxt_fstat;
            wstat_ff <= nxt_wstat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault and warning pins

    reg flatch_ff;
    reg wlatch_ff;
    reg heat_hold_ff;
    reg hiz_hold_ff;
    reg fault_oe_ff;
    reg warn_oe_ff;

    // Masks act here only, status above is untouched
    wire fset = (ev_volt & ~fmask_ff[`FM_VOLT])
              | (ev_clk & ~fmask_ff[`FM_CLK])
              | (ev_chan & ~fmask_ff[`FM_CHAN]);
    wire wset = (clip_evt & ~wmask_ff[`WM_CLIP])
              | (ev_hwarn & ~wmask_ff[`WM_HEAT])
              | (ev_clamp & ~wmask_ff[`WM_CLAMP]);

    wire nxt_flatch = (flatch_ff & ~clear) | fset;
    wire nxt_wlatch = (wlatch_ff & ~clear) | wset;
    // Heat hold drops by itself when recovery is enabled
    wire nxt_heat_hold = ev_hsd | (heat_hold_ff & ~autorec & ~clear);
    wire nxt_hiz_hold = (hiz_hold_ff & ~clear) | ev_volt | ev_clk | ev_chan;
    wire nxt_fault_oe = nxt_flatch | (nxt_heat_hold & ~fmask_ff[`FM_HEAT]);

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flatch_ff <= 1'b0;
            wlatch_ff <= 1'b1;
            heat_hold_ff <= 1'b0;
            hiz_hold_ff <= 1'b0;
            fault_oe_ff <= 1'b0;
            warn_oe_ff <= 1'b1;
        end else if (clk_en) begin
            flatch_ff <= nxt_flatch;
            wlatch_ff <= nxt_wlatch;
            heat_hold_ff <= nxt_heat_hold;
            hiz_hold_ff <= nxt_hiz_hold;
            fault_oe_ff <= nxt_fault_oe;
            warn_oe_ff <= nxt_wlatch;
        end
    end

    // Pins only ever pull low; the line floats high otherwise
    assign fault_n_o = 1'b0;
    assign warn_n_o = 1'b0;
    assign fault_n_oe = fault_oe_ff;
    assign warn_n_oe = warn_oe_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Operating state machine

    reg [RAMP_W-1:0] ramp_cnt_ff;
    reg [RAMP_W-1:0] nxt_ramp;
    reg [2:0] nxt_st;
    reg [2:0] target;

    // Heat warning takes no action on the stage
    always @* begin
        if (hiz_hold_ff | heat_hold_ff) begin
            target = ST_HIZ;
        end else if (req_ff == ST_STBY[1:0]) begin
            target = ST_STBY;
        end else if (req_ff == ST_HIZ[1:0]) begin
            target = ST_HIZ;
        end else if (mute_req || req_ff == ST_MUTE[1:0]) begin
            target = ST_MUTE;
        end else begin
            target = ST_PLAY;
        end
    end

    always @* begin
        nxt_st = st_ff;
        nxt_ramp = ramp_cnt_ff;
        case (st_ff)
            ST_STBY: begin
                // A software standby request must not bounce through high-Z
                if (!stby_req && target != ST_STBY) begin
                    nxt_st = ST_HIZ;
                end
            end
            ST_RAMP: begin
                if (ramp_cnt_ff == {RAMP_W{1'b0}}) begin
                    nxt_st = ST_STBY;
                end else begin
                    nxt_ramp = ramp_cnt_ff - {{(RAMP_W-1){1'b0}}, 1'b1};
                end
            end
            ST_HIZ, ST_MUTE, ST_PLAY: begin
                if (stby_req) begin
                    if (st_ff == ST_HIZ) begin
                        nxt_st = ST_STBY;
                    end else begin
                        nxt_st = ST_RAMP;
                        nxt_ramp = RAMP_LD;
                    end
                end else begin
                    nxt_st = target;
                end
            end
            default: begin
                nxt_st = ST_STBY;
            end
        endcase
    end

    // Reset is the power-on event and lands in standby
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= ST_STBY;
            osc_run_ff <= 1'b0;
            ramp_cnt_ff <= {RAMP_W{1'b0}};
        end else if (clk_en) begin
            st_ff <= nxt_st;
            osc_run_ff <= (nxt_st != ST_STBY);
            ramp_cnt_ff <= nxt_ramp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign stage_state = st_ff;
    assign osc_run = osc_run_ff;
    assign heat_thr = misc1_ff[`MISC1_THR_HI:`MISC1_THR_LO];
    assign clamp_lvl = misc1_ff[`MISC1_CLAMP];

endmodule // amp_supervisor

/* tb/amp_supervisor_assertions.sv */
`timescale 1ns/1ps
module amp_supervisor_assertions #(
    parameter RAMP_CYC = 20
) (
    // Clock and reset
    input wire core_clk,
    input wire arst_n,
    input wire clk_en,
    // Register bus
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    // Pins and state
    input wire [9:0] ev_pin,
    input wire fault_n_o,
    input wire fault_n_oe,
    input wire warn_n_o,
    input wire warn_n_oe,
    input wire [2:0] stage_state,
    input wire osc_run
);
    localparam int RAMP_MAX = RAMP_CYC + 20;
    wire acc = psel && penable && clk_en;
    wire clr_wr = acc && pready && pwrite && paddr == 12'h084 && pwdata[7];
    reg [2:0] heat_ff;
    ////////////////////////////////////////////////////////////////////////
    // Heat release lags the pin by the synchroniser, so remember it a while
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            heat_ff <= 3'h0;
        else if (ev_pin[3])
            heat_ff <= 3'h7;
        else if (heat_ff != 3'h0)
            heat_ff <= heat_ff - 3'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence ramp_hold;
        (stage_state == 3'h4)[*8];
    endsequence
    a_ready_wait: assert property (acc && !pready |=> pready) else $error("pready late");
    a_ready_once: assert property (pready && clk_en |=> !pready) else $error("pready stuck");
    a_err_unmapped: assert property (acc && !pready && paddr[11:10] != 2'h0 |=> pslverr)
        else $error("no slave error");
    a_err_ready: assert property (pslverr |-> pready) else $error("stray slave error");
    a_od_low:
        assert property (!fault_n_o && !warn_n_o) else $error("open drain value high");
    a_osc_state:
        assert property (osc_run == (stage_state != 3'h0)) else $error("osc vs state");
    a_fault_latched:
        assert property ($fell(fault_n_oe) |-> $past(clr_wr) || heat_ff != 3'h0)
        else $error("fault released early");
    a_warn_latched:
        assert property ($fell(warn_n_oe) |-> $past(clr_wr)) else $error("warn released");
    a_ramp_down:
        assert property ($rose(stage_state == 3'h4) |-> ramp_hold ##[1:RAMP_MAX] stage_state == 3'h0)
        else $error("ramp length");
    a_por_warn:
        assert property ($rose(arst_n) |-> warn_n_oe && !fault_n_oe && stage_state == 3'h0)
        else $error("power-on state wrong");
    a_standby_exit:
        assert property ($past(stage_state) == 3'h0 && stage_state != 3'h0 |-> stage_state == 3'h1)
        else $error("standby exit");
endmodule // amp_supervisor_assertions

bind amp_supervisor amp_supervisor_assertions #(.RAMP_CYC(RAMP_CYC)) u_chk (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .ev_pin(ev_pin), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .warn_n_o(warn_n_o),
    .warn_n_oe(warn_n_oe), .stage_state(stage_state), .osc_run(osc_run)
);

/* tb/amp_host_pins.sv */
`timescale 1ns/1ps
module amp_host_pins (
    // Host mute driver
    input wire mute_drv,
    input wire mute_lvl,
    // Open-drain status outputs
    input wire fault_n_o,
    input wire fault_n_oe,
    input wire warn_n_o,
    input wire warn_n_oe,
    // Resolved pins
    output wire mute_n,
    output wire fault_w,
    output wire warn_w
);
    // Pull-ups hold released status lines high
    assign fault_w = fault_n_oe ? fault_n_o : 1'b1;
    assign warn_w = warn_n_oe ? warn_n_o : 1'b1;
    // Floating mute falls to the pull-down level
    assign mute_n = mute_drv ? mute_lvl : 1'b0;
endmodule // amp_host_pins

/* tb/amp_supervisor_tb.sv */
`timescale 1ns/1ps
`include "amp_supervisor_consts.vh"
module amp_supervisor_tb;
    logic core_clk = '0, arst_n = '0, clk_en = '1, psel = '0, penable = '0, pwrite = '0;
    logic pwm_tick = '0, max_mod = '0, standby_n = '0, mute_drv = '1, mute_lvl = '1;
    logic tick_on = '0, er, pready, pslverr, fault_n_o, fault_n_oe, warn_n_o, warn_n_oe;
    logic osc_run, clamp_lvl;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [9:0] ev_pin = '0;
    logic [2:0] stage_state;
    logic [1:0] heat_thr;
    wire mute_n, fault_w, warn_w;
    int err_total = 0, n_tests = 0;
    amp_supervisor #(.RAMP_CYC(20)) dut (
        .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ev_pin(ev_pin),
        .pwm_tick(pwm_tick), .max_mod(max_mod), .mute_n(mute_n), .standby_n(standby_n),
        .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .warn_n_o(warn_n_o),
        .warn_n_oe(warn_n_oe), .stage_state(stage_state), .osc_run(osc_run),
        .heat_thr(heat_thr), .clamp_lvl(clamp_lvl)
    );
    amp_host_pins host (
        .mute_drv(mute_drv), .mute_lvl(mute_lvl), .fault_n_o(fault_n_o),
        .fault_n_oe(fault_n_oe), .warn_n_o(warn_n_o), .warn_n_oe(warn_n_oe),
        .mute_n(mute_n), .fault_w(fault_w), .warn_w(warn_w)
    );
    always #12.5 core_clk = ~core_clk;
    // Tick every other cycle, so a window of N ticks spans 2N cycles
    always @(posedge core_clk) pwm_tick <= tick_on ? ~pwm_tick : 1'b0;
    ////////////////////////////////////////////////////////////////////////
    task automatic waitc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        logic ok;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        ok = 1'b0;
        // Look mid-cycle where outputs are settled; the answer counts at the next rising edge
        while (ok !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            ok = pready;
            rd = prdata;
            er = pslverr;
            n++;
            @(posedge core_clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (ok !== 1'b1) begin
            chk("pready", 1, ok);
            end_sim();
        end
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        rw(1'b1, {2'h0, i, 2'h0}, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] i, input logic [31:0] e);
        rw(1'b0, {2'h0, i, 2'h0}, '0);
        chk(nm, e, rd);
    endtask
    task automatic clr();
        wr(`IDX_MISC3, 32'h80);
        waitc(2);
    endtask
    task automatic do_reset();
        standby_n <= 1'b0;
        waitc(2);
        arst_n <= 1'b0;
        waitc(8);
        arst_n <= 1'b1;
        waitc(1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("warn oe", 1, warn_n_oe);
        chk("warn pin", 0, warn_w);
        chk("stage", 0, stage_state);
        rdc("wstat", `IDX_WSTAT, 32'h1);
        rdc("clipwin", `IDX_CLIPWIN, 32'h14);
        rdc("misc1", `IDX_MISC1, 32'h0);
        rdc("fmask", `IDX_FMASK, 32'h0);
        rdc("wmask", `IDX_WMASK, 32'h0);
        rdc("state", `IDX_STATE, 32'h1);
        rw(1'b0, 12'hC00, '0);
        chk("slverr", 1, er);
        clr();
        chk("warn clr", 0, warn_n_oe);
    endtask
    task automatic t_fault();
        for (int i = 0; i < 7; i++) begin
            ev_pin[i] <= 1'b1;
            waitc(4);
            chk("fault oe", 1, fault_n_oe);
            chk("fault pin", 0, fault_w);
            ev_pin[i] <= 1'b0;
            waitc(4);
            chk("fault held", 1, fault_n_oe);
            rdc("fstat", `IDX_FSTAT, 32'h1 << i);
            clr();
            chk("fault clr", 0, fault_n_oe);
            rdc("fstat clr", `IDX_FSTAT, 32'h0);
        end
        // One source per mask category: voltage, heat shutdown, clock, channel
        for (int j = 0; j < 4; j++) begin
            int k;
            k = (j == 0) ? 0 : (j == 1) ? 3 : j + 2;
            wr(`IDX_FMASK, 32'h1 << j);
            ev_pin[k] <= 1'b1;
            waitc(4);
            chk("fault masked", 0, fault_n_oe);
            rdc("fstat masked", `IDX_FSTAT, 32'h1 << k);
            ev_pin[k] <= 1'b0;
            waitc(4);
            clr();
        end
        wr(`IDX_FMASK, 32'h0);
    endtask
    task automatic t_state();
        standby_n <= 1'b1;
        waitc(6);
        chk("stage hiz", 1, stage_state);
        wr(`IDX_STATE, 32'h3);
        waitc(3);
        chk("stage play", 3, stage_state);
        mute_drv <= 1'b0;
        waitc(4);
        chk("stage mute", 2, stage_state);
        mute_drv <= 1'b1;
        waitc(4);
        rdc("mode", `IDX_MODE, 32'hB);
        wr(`IDX_STATE, 32'h2);
        waitc(2);
        chk("req mute", 2, stage_state);
        wr(`IDX_STATE, 32'h0);
        waitc(2);
        chk("req stby", 0, stage_state);
        waitc(1);
        chk("stby hold", 0, stage_state);
        chk("stby osc", 0, osc_run);
        wr(`IDX_STATE, 32'h3);
        waitc(3);
        chk("req play", 3, stage_state);
        wr(`IDX_MISC3, 32'h08);
        ev_pin[3] <= 1'b1;
        waitc(5);
        chk("heat hiz", 1, stage_state);
        chk("heat fault", 1, fault_n_oe);
        ev_pin[3] <= 1'b0;
        waitc(5);
        chk("heat release", 0, fault_n_oe);
        chk("heat resume", 3, stage_state);
        clr();
        standby_n <= 1'b0;
        waitc(4);
        chk("stage ramp", 4, stage_state);
        waitc(22);
        chk("stage standby", 0, stage_state);
        chk("osc stop", 0, osc_run);
    endtask
    task automatic t_clip();
        max_mod <= 1'b1;
        tick_on <= 1'b1;
        // Read sampled on the edge the count reaches the window; a read one cycle later would still see the flag clear
        waitc(38);
        rdc("clip early", `IDX_WSTAT, 32'h0);
        waitc(10);
        rdc("clip set", `IDX_WSTAT, 32'h2);
        chk("clip pin", 1, warn_n_oe);
        max_mod <= 1'b0;
        waitc(4);
        rdc("clip held", `IDX_WSTAT, 32'h2);
        clr();
        rdc("clip clr", `IDX_WSTAT, 32'h0);
        chk("warn clr", 0, warn_n_oe);
        wr(`IDX_MISC3, 32'h1);
        max_mod <= 1'b1;
        waitc(3);
        rdc("clip free on", `IDX_WSTAT, 32'h2);
        max_mod <= 1'b0;
        waitc(3);
        rdc("clip free off", `IDX_WSTAT, 32'h0);
        tick_on <= 1'b0;
        clr();
    endtask
    task automatic t_warn();
        wr(`IDX_MISC1, 32'h70);
        chk("heat thr", 3, heat_thr);
        chk("clamp lvl", 1, clamp_lvl);
        for (int i = 7; i < 10; i++) begin
            ev_pin[i] <= 1'b1;
            waitc(4);
            chk("warn src", 1, warn_n_oe);
            ev_pin[i] <= 1'b0;
            waitc(4);
            rdc("wstat src", `IDX_WSTAT, (i == 9) ? 32'h8 : 32'h4);
            clr();
            chk("warn src clr", 0, warn_n_oe);
        end
        wr(`IDX_WMASK, 32'h2);
        ev_pin[7] <= 1'b1;
        waitc(4);
        chk("warn masked", 0, warn_n_oe);
        rdc("wstat masked", `IDX_WSTAT, 32'h4);
        ev_pin[7] <= 1'b0;
        waitc(4);
        clr();
        wr(`IDX_WMASK, 32'h0);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        t_reset();
        t_fault();
        t_state();
        t_clip();
        t_warn();
        do_reset();
        t_reset();
        end_sim();
    end
endmodule // amp_supervisor_tb
